// File: hdl/ctab_top.sv
/*
 * Transmit abort, abort acknowledge, buffer empty flags and empty
 * interrupt enables for a three-buffer CAN transmitter, behind an
 * Avalon-MM slave with waitrequest.
 * Assumes the transmit engine gives one-cycle outcome pulses per
 * buffer on ref_clk and the mode logic gives the init handshake levels.
 */
`timescale 1ns/100ps
`default_nettype none

module ctab_top (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Avalon-MM slave
	input wire ctab_pkg::ctab_av_req_t av_req,
	output logic [ctab_pkg::DATA_W-1:0] av_readdata,
	output logic av_waitrequest,
	// Mode handshake
	input wire logic init_mode_request,
	input wire logic init_mode_ack,
	// Transmit engine
	input wire ctab_pkg::ctab_tx_evt_t tx_evt,
	output logic [ctab_pkg::NBUF-1:0] tx_scheduled,
	// Interrupts
	output logic tx_empty_irq,
	output logic evt_irq
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic init_mode;
	logic ack_q, ack_d;
	logic [ctab_pkg::DATA_W-1:0] rdata_q, rdata_d;
	logic [ctab_pkg::NBUF-1:0] empty_q, empty_d;
	logic [ctab_pkg::NBUF-1:0] irq_en_q, irq_en_d;
	logic [ctab_pkg::NBUF-1:0] abort_req_q, abort_req_d;
	logic [ctab_pkg::NBUF-1:0] abort_done_q, abort_done_d;
	logic [ctab_pkg::NBUF-1:0] busy_q, busy_d;
	logic [ctab_pkg::EVT_W-1:0] evt_sts_q, evt_sts_d;
	logic [ctab_pkg::EVT_W-1:0] evt_mask_q, evt_mask_d;
	logic [ctab_pkg::NBUF-1:0] grant, sent, empty_set, empty_clr, wbuf;
	logic [ctab_pkg::IDX_W-1:0] idx;
	logic wr_ok;

	// Write strobe of one register, taken on the edge ending the cycle after the wait
	function automatic logic wr_hit(input logic [ctab_pkg::IDX_W-1:0] ri);
		wr_hit = wr_ok && (idx == ri);
	endfunction

	assign init_mode = init_mode_request & init_mode_ack;
	assign idx = av_req.address[ctab_pkg::IDX_LSB +: ctab_pkg::IDX_W];
	assign wr_ok = av_req.write & ack_q & av_req.byteenable[0];
	assign wbuf = av_req.writedata[ctab_pkg::NBUF-1:0];

	// ----------------------------------------------------------------
	// Bus slave: one wait cycle on every access
	// ----------------------------------------------------------------
	assign av_waitrequest = (av_req.read | av_req.write) & ~ack_q;
	assign av_readdata = rdata_q;

	always_comb begin
		ack_d = (av_req.read | av_req.write) & ~ack_q;
		rdata_d = rdata_q;
		if (av_req.read && !ack_q) begin
			rdata_d = ctab_pkg::RD_ZERO;
			case (idx)
				ctab_pkg::IDX_EMPTY_FLAGS: rdata_d[ctab_pkg::NBUF-1:0] = empty_q;
				ctab_pkg::IDX_IRQ_ENABLE: rdata_d[ctab_pkg::NBUF-1:0] = irq_en_q;
				ctab_pkg::IDX_ABORT_REQ: rdata_d[ctab_pkg::NBUF-1:0] = abort_req_q;
				ctab_pkg::IDX_ABORT_ACK: rdata_d[ctab_pkg::NBUF-1:0] = abort_done_q;
				ctab_pkg::IDX_EVT_STATUS: rdata_d[ctab_pkg::EVT_W-1:0] = evt_sts_q;
				ctab_pkg::IDX_EVT_MASK: rdata_d[ctab_pkg::EVT_W-1:0] = evt_mask_q;
				default: rdata_d = ctab_pkg::RD_ZERO;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ack_q <= 1'b0;
			rdata_q <= ctab_pkg::RD_ZERO;
		end else begin
			ack_q <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	// ----------------------------------------------------------------
	// Buffer flags, abort handling and event status
	// ----------------------------------------------------------------
	always_comb begin
		// Abort wins before start, or when the attempt fails
		grant = abort_req_q & ~empty_q & (~busy_q | tx_evt.fail);
		sent = tx_evt.sent_ok & ~empty_q & ~grant;
		empty_set = grant | sent;
		empty_clr = wr_hit(ctab_pkg::IDX_EMPTY_FLAGS) ? (wbuf & empty_q) : ctab_pkg::BUF_RST;

		empty_d = (empty_q & ~empty_clr) | empty_set;
		// A failed attempt without abort stays queued for retry
		busy_d = (busy_q | (tx_evt.start & ~empty_q)) & ~tx_evt.fail & ~empty_set;

		irq_en_d = irq_en_q;
		if (wr_hit(ctab_pkg::IDX_IRQ_ENABLE)) begin
			irq_en_d = wbuf;
		end

		// Ones only set; requests on empty buffers are dropped
		abort_req_d = abort_req_q;
		if (wr_hit(ctab_pkg::IDX_ABORT_REQ)) begin
			abort_req_d = abort_req_q | (wbuf & ~empty_q);
		end
		abort_req_d = abort_req_d & ~empty_set;

		// Writes to this index are ignored; a write that clears an empty flag clears that buffer's bit
		abort_done_d = (abort_done_q & ~empty_clr) | grant;

		// Set wins over the write-one clear
		evt_sts_d = evt_sts_q;
		if (wr_hit(ctab_pkg::IDX_EVT_STATUS)) begin
			evt_sts_d = evt_sts_q & ~av_req.writedata[ctab_pkg::EVT_W-1:0];
		end
		evt_sts_d = evt_sts_d | {grant, empty_set};

		evt_mask_d = evt_mask_q;
		if (wr_hit(ctab_pkg::IDX_EVT_MASK)) begin
			evt_mask_d = av_req.writedata[ctab_pkg::EVT_W-1:0];
		end

		if (init_mode) begin
			empty_d = ctab_pkg::EMPTY_RST;
			busy_d = ctab_pkg::BUF_RST;
			irq_en_d = ctab_pkg::BUF_RST;
			abort_req_d = ctab_pkg::BUF_RST;
			abort_done_d = ctab_pkg::BUF_RST;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			empty_q <= ctab_pkg::EMPTY_RST;
			busy_q <= ctab_pkg::BUF_RST;
			irq_en_q <= ctab_pkg::BUF_RST;
			abort_req_q <= ctab_pkg::BUF_RST;
			abort_done_q <= ctab_pkg::BUF_RST;
			evt_sts_q <= ctab_pkg::EVT_RST;
			evt_mask_q <= ctab_pkg::EVT_RST;
		end else begin
			empty_q <= empty_d;
			busy_q <= busy_d;
			irq_en_q <= irq_en_d;
			abort_req_q <= abort_req_d;
			abort_done_q <= abort_done_d;
			evt_sts_q <= evt_sts_d;
			evt_mask_q <= evt_mask_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign tx_scheduled = ~empty_q;
	assign tx_empty_irq = |(empty_q & irq_en_q);
	assign evt_irq = |(evt_sts_q & evt_mask_q);

endmodule // ctab_top

`default_nettype wire

// File: include/ctab_pkg.sv
/*
 * Package for the CAN transmit abort and interrupt enable slice:
 * register indices, field widths, reset values and carrier structs.
 * Assumes a 32-bit Avalon-MM slave with byte addresses.
 */
`default_nettype none

package ctab_pkg;

	// ----------------------------------------------------------------
	// Register map (index; byte address is four times the index)
	// ----------------------------------------------------------------
	localparam int unsigned NBUF = 3;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned IDX_W = 6;
	localparam logic [IDX_W-1:0] IDX_EMPTY_FLAGS = 6'h06;
	localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 6'h07;
	localparam logic [IDX_W-1:0] IDX_ABORT_REQ = 6'h08;
	localparam logic [IDX_W-1:0] IDX_ABORT_ACK = 6'h09;
	localparam logic [IDX_W-1:0] IDX_EVT_STATUS = 6'h10;
	localparam logic [IDX_W-1:0] IDX_EVT_MASK = 6'h11;
	localparam int unsigned IDX_LSB = 2;

	// ----------------------------------------------------------------
	// Field layout and reset values
	// ----------------------------------------------------------------
	localparam int unsigned EVT_W = 2 * NBUF;
	localparam logic [NBUF-1:0] EMPTY_RST = 3'h7;
	localparam logic [NBUF-1:0] BUF_RST = 3'h0;
	localparam logic [EVT_W-1:0] EVT_RST = 6'h00;
	localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	// Per-buffer outcome pulses from the transmit engine
	typedef struct packed {
		logic [NBUF-1:0] start;
		logic [NBUF-1:0] sent_ok;
		logic [NBUF-1:0] fail;
	} ctab_tx_evt_t;

	// Avalon-MM request from the CPU side
	typedef struct packed {
		logic [ADDR_W-1:0] address;
		logic read;
		logic write;
		logic [DATA_W-1:0] writedata;
		logic [3:0] byteenable;
	} ctab_av_req_t;

endpackage

`default_nettype wire

// File: tb/ctab_assertions.sv
/* Port checker for ctab_top, bound to every instance.
   Assumes a master that holds each request until waitrequest is low. */
`timescale 1ns/100ps
`default_nettype none
module ctab_chk (
	// Clock, reset and bus
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire ctab_pkg::ctab_av_req_t av_req,
	input wire logic [ctab_pkg::DATA_W-1:0] av_readdata,
	input wire logic av_waitrequest,
	// Mode, engine and interrupts
	input wire logic init_mode_request,
	input wire logic init_mode_ack,
	input wire ctab_pkg::ctab_tx_evt_t tx_evt,
	input wire logic [ctab_pkg::NBUF-1:0] tx_scheduled,
	input wire logic tx_empty_irq,
	input wire logic evt_irq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	init_hold_a: assert property ((init_mode_request && init_mode_ack) |=>
		tx_scheduled == 3'h0 && !tx_empty_irq) else $error("init mode left state");
	first_wait_a: assert property ($rose(av_req.read) |-> av_waitrequest)
		else $error("read answered without wait");
	wait_one_a: assert property ((av_req.read || av_req.write) && av_waitrequest |=>
		!av_waitrequest) else $error("wait longer than one cycle");
	idle_ready_a: assert property (!(av_req.read || av_req.write) |-> !av_waitrequest)
		else $error("wait without request");
	sent_empty_a: assert property ((tx_evt.sent_ok & tx_scheduled) != 3'h0 |=>
		(tx_scheduled & $past(tx_evt.sent_ok)) == 3'h0) else $error("sent buffer kept");
	irq_gate_a: assert property (tx_empty_irq |-> tx_scheduled != 3'h7)
		else $error("irq with no empty buffer");
	sched_cause_a: assert property ((tx_scheduled & ~$past(tx_scheduled)) != 3'h0 |->
		$past(av_req.write && !av_waitrequest)) else $error("schedule without write");
	upper_zero_a: assert property (av_req.read && !av_waitrequest |->
		av_readdata[31:6] == 26'h0) else $error("upper read bits set");
endmodule // ctab_chk
bind ctab_top ctab_chk u_chk (.*);
`default_nettype wire

// File: tb/ctab_engine.sv
/* Transmit engine stand-in: one-cycle start and outcome pulses on buffer 0.
   Assumes the bench raises go and fin for one cycle at a time; lose may stay high and counts only with fin. */
`timescale 1ns/100ps
`default_nettype none
module ctab_engine (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Bench controls and scheduled flags
	input wire logic go,
	input wire logic fin,
	input wire logic lose,
	input wire logic [2:0] tx_scheduled,
	// Outcome pulses
	output wire ctab_pkg::ctab_tx_evt_t tx_evt
);
	ctab_pkg::ctab_tx_evt_t evt_d;
	ctab_pkg::ctab_tx_evt_t evt_q;
	always_comb begin
		evt_d = '0;
		evt_d.start[0] = go && tx_scheduled[0];
		evt_d.sent_ok[0] = fin && !lose;
		evt_d.fail[0] = fin && lose;
	end
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) evt_q <= '0;
		else evt_q <= evt_d;
	end
	assign tx_evt = evt_q;
endmodule // ctab_engine
`default_nettype wire

// File: tb/tb.sv
/* Self-checking bench for ctab_top with the engine stand-in.
   Polls waitrequest for up to 20 rising edges on each bus access. */
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic go = 1'b0, fin = 1'b0, lose = 1'b0, init = 1'b0, init_ack = 1'b0;
	ctab_pkg::ctab_av_req_t req = 46'h1;
	logic [31:0] rdata, r;
	ctab_pkg::ctab_tx_evt_t evt;
	logic [2:0] sched;
	logic irq, eirq, wreq;
	int fail_count = 0, n_checks = 0;
	always #50 ref_clk = ~ref_clk;
	ctab_top dut (.ref_clk(ref_clk), .reset_n(reset_n), .av_req(req), .av_readdata(rdata),
		.av_waitrequest(wreq), .init_mode_request(init), .init_mode_ack(init_ack),
		.tx_evt(evt), .tx_scheduled(sched), .tx_empty_irq(irq), .evt_irq(eirq));
	ctab_engine u_eng (.ref_clk(ref_clk), .reset_n(reset_n), .go(go), .fin(fin),
		.lose(lose), .tx_scheduled(sched), .tx_evt(evt));
	task automatic tally_and_finish;
		if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [5:0] i, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		req.address <= {i, 2'b00};
		req.read <= !w;
		req.write <= w;
		req.writedata <= d;
		// Waitrequest and read data are judged at the rising edge itself
		do begin
			@(posedge ref_clk);
			n++;
		end while (wreq !== 1'b0 && n < 20);
		r = rdata;
		if (wreq !== 1'b0) begin
			fail_count++;
			tally_and_finish();
		end
		req.read <= 1'b0;
		req.write <= 1'b0;
		@(negedge ref_clk);
	endtask
	task automatic rc(input logic [5:0] i, input logic [31:0] e, input string s);
		bus(1'b0, i, 32'h0);
		chk(s, e, r);
	endtask
	task automatic t_reset;
		rc(6'h07, 32'h0, "enable");
		rc(6'h09, 32'h0, "ack");
		rc(6'h06, 32'h7, "empty");
		rc(6'h03, 32'h0, "unmapped");
	endtask
	task automatic t_idle_abort;
		bus(1'b1, 6'h06, 32'h1);
		bus(1'b1, 6'h06, 32'h0);
		rc(6'h06, 32'h6, "empty");
		bus(1'b1, 6'h08, 32'h1);
		rc(6'h09, 32'h1, "ack");
		rc(6'h08, 32'h0, "req");
		bus(1'b1, 6'h09, 32'h0);
		rc(6'h09, 32'h1, "ack kept");
		rc(6'h10, 32'h9, "status");
		chk("evt irq", 32'h0, 32'(eirq));
		bus(1'b1, 6'h11, 32'h8);
		chk("evt irq", 32'h1, 32'(eirq));
		bus(1'b1, 6'h10, 32'h3f);
		chk("evt irq", 32'h0, 32'(eirq));
		bus(1'b1, 6'h06, 32'h1);
		rc(6'h09, 32'h0, "ack clr");
	endtask
	task automatic t_started(input logic l);
		bus(1'b1, 6'h06, 32'h1);
		@(posedge ref_clk);
		go <= 1'b1;
		@(posedge ref_clk);
		go <= 1'b0;
		bus(1'b1, 6'h08, 32'h1);
		rc(6'h06, 32'h6, "busy");
		@(posedge ref_clk);
		lose <= l;
		fin <= 1'b1;
		@(posedge ref_clk);
		fin <= 1'b0;
		rc(6'h09, {31'h0, l}, "ack out");
		rc(6'h06, 32'h7, "empty out");
		rc(6'h08, 32'h0, "req out");
	endtask
	task automatic t_init;
		bus(1'b1, 6'h07, 32'h7);
		chk("irq", 32'h1, 32'(irq));
		bus(1'b1, 6'h07, 32'h6);
		bus(1'b1, 6'h06, 32'h6);
		chk("irq", 32'h0, 32'(irq));
		// Request alone is not init mode: writes still land
		@(posedge ref_clk);
		init <= 1'b1;
		bus(1'b1, 6'h07, 32'h5);
		rc(6'h07, 32'h5, "en req only");
		@(posedge ref_clk);
		init_ack <= 1'b1;
		bus(1'b1, 6'h07, 32'h7);
		bus(1'b1, 6'h08, 32'h6);
		rc(6'h07, 32'h0, "en init");
		rc(6'h08, 32'h0, "req init");
		chk("sched", 32'h0, 32'(sched));
		@(posedge ref_clk);
		init <= 1'b0;
		init_ack <= 1'b0;
	endtask
	initial begin
		repeat (2) @(posedge ref_clk);
		reset_n <= 1'b1;
		t_reset();
		t_idle_abort();
		t_started(1'b0);
		t_started(1'b1);
		t_init();
		tally_and_finish();
	end
endmodule // tb
`default_nettype wire
